// ===== verilog/asi_pkg.sv
// Notes on behaviour
// - Overrange detect enabled sets primary overrange flag.
// - Overrange condition sampled once every 125 us.
// - Overrange flag cleared by detect disable or gain change.
// - Aux result write or calibration end sets aux ready.
// - Aux ready clears after aux read then primary read.
// - Primary result write or calibration end sets ready.
// - Mask bits align with status bits; one enables.
// - Mask register resets to all zeros.
// - Mask enables at bits 6,4,3,1,0; rest reserved.
// - Mode register is 8-bit read-write, resets 0x03.
// - Status bit 6 follows accumulator threshold exceeded.
// - Continuous mode drops new result until ready cleared.
`default_nettype none
package asi_pkg;
   localparam logic [31:0] ADDR_STATUS = 32'hffff0500;
   localparam logic [31:0] ADDR_MASK = 32'hffff0504;
   localparam logic [31:0] ADDR_MODE = 32'hffff0508;
   localparam logic [31:0] ADDR_CLEAR = 32'hffff050c;
   localparam logic [31:0] ADDR_CONFIG = 32'hffff0510;
   localparam logic [31:0] ADDR_PCTRL = 32'hffff0514;
   localparam logic [31:0] ADDR_PDATA = 32'hffff0518;
   localparam logic [31:0] ADDR_ADATA = 32'hffff051c;

   localparam int BIT_PRDY = 0;
   localparam int BIT_ARDY = 1;
   localparam int BIT_OVR = 3;
   localparam int BIT_CTH = 4;
   localparam int BIT_ATH = 6;
   localparam logic [7:0] MASK_WRITABLE = 8'h5b;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h03;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] PCTRL_RST = 8'h00;
   localparam int CFG_OVR_EN_BIT = 2;
   localparam int GAIN_LSB = 0;
   localparam int GAIN_W = 4;
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 3;
   localparam logic [2:0] MODE_CONTINUOUS = 3'h1;

   localparam int OVR_TICK_NS = 125000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int OVR_TICK_CYCLES = OVR_TICK_NS / CLK_PERIOD_NS;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Word match of a byte address against a register offset.
   function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] off);
      return a[31:2] == off[31:2];
   endfunction
endpackage
`default_nettype wire

// ===== verilog/asi_csr_if.sv
`default_nettype none
interface asi_csr_if;
   logic wr_en;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic rd_en;
   logic [31:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// ===== verilog/asi_axil_slave.sv
`default_nettype none
module asi_axil_slave (
   input wire logic i_clk,            // System clock.
   input wire logic i_sys_rst,        // Synchronous reset, active high.
   input wire logic [31:0] i_awaddr,  // Write address.
   input wire logic i_awvalid,        // Write address valid.
   output logic o_awready,            // Write address ready.
   input wire logic [31:0] i_wdata,   // Write data.
   input wire logic [3:0] i_wstrb,    // Write byte strobes.
   input wire logic i_wvalid,         // Write data valid.
   output logic o_wready,             // Write data ready.
   output logic [1:0] o_bresp,        // Write response.
   output logic o_bvalid,             // Write response valid.
   input wire logic i_bready,         // Write response ready.
   input wire logic [31:0] i_araddr,  // Read address.
   input wire logic i_arvalid,        // Read address valid.
   output logic o_arready,            // Read address ready.
   output logic [31:0] o_rdata,       // Read data.
   output logic [1:0] o_rresp,        // Read response.
   output logic o_rvalid,             // Read data valid.
   input wire logic i_rready,         // Read data ready.
   asi_csr_if.bus csr                 // Register access toward the block.
);
   logic aw_full_q;
   logic w_full_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // Address and data are each taken once and held until the response is accepted.
   assign o_awready = !aw_full_q && !bvalid_q;
   assign o_wready = !w_full_q && !bvalid_q;
   assign o_arready = !rvalid_q;
   assign csr.wr_en = aw_full_q && w_full_q && !bvalid_q;
   assign csr.wr_addr = awaddr_q;
   assign csr.wr_data = wdata_q;
   assign csr.wr_strb = wstrb_q;
   assign csr.rd_en = i_arvalid && !rvalid_q;
   assign csr.rd_addr = i_araddr;
   assign o_bvalid = bvalid_q;
   assign o_bresp = bresp_q;
   assign o_rvalid = rvalid_q;
   assign o_rdata = rdata_q;
   assign o_rresp = rresp_q;

   // Write channel capture and response.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 32'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= asi_pkg::RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_full_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
         end
         if (csr.wr_en) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= csr.wr_ok ? asi_pkg::RESP_OKAY : asi_pkg::RESP_SLVERR;
         end else if (bvalid_q && i_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read channel: data are registered in the cycle the address is taken.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= asi_pkg::RESP_OKAY;
      end else if (csr.rd_en) begin
         rvalid_q <= 1'b1;
         rdata_q <= csr.rd_data;
         rresp_q <= csr.rd_ok ? asi_pkg::RESP_OKAY : asi_pkg::RESP_SLVERR;
      end else if (rvalid_q && i_rready) begin
         rvalid_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/asi_top.sv
`default_nettype none
module asi_top #(
   parameter int OVR_TICK_CYCLES = asi_pkg::OVR_TICK_CYCLES,
   parameter int RES_W = 32
) (
   input wire logic i_clk,                   // System clock, 50 MHz.
   input wire logic i_sys_rst,               // Synchronous reset, active high.
   input wire logic [31:0] i_awaddr,         // AXI write address.
   input wire logic i_awvalid,               // AXI write address valid.
   output logic o_awready,                   // AXI write address ready.
   input wire logic [31:0] i_wdata,          // AXI write data.
   input wire logic [3:0] i_wstrb,           // AXI write strobes.
   input wire logic i_wvalid,                // AXI write data valid.
   output logic o_wready,                    // AXI write data ready.
   output logic [1:0] o_bresp,               // AXI write response.
   output logic o_bvalid,                    // AXI write response valid.
   input wire logic i_bready,                // AXI write response ready.
   input wire logic [31:0] i_araddr,         // AXI read address.
   input wire logic i_arvalid,               // AXI read address valid.
   output logic o_arready,                   // AXI read address ready.
   output logic [31:0] o_rdata,              // AXI read data.
   output logic [1:0] o_rresp,               // AXI read response.
   output logic o_rvalid,                    // AXI read valid.
   input wire logic i_rready,                // AXI read ready.
   input wire logic i_primary_en,            // Primary converter enabled.
   input wire logic i_aux_en,                // Auxiliary converter enabled.
   input wire logic i_primary_wr,            // Primary result write strobe.
   input wire logic [RES_W-1:0] i_primary_res, // Primary result value.
   input wire logic i_aux_wr,                // Auxiliary result write strobe.
   input wire logic [RES_W-1:0] i_aux_res,   // Auxiliary result value.
   input wire logic i_cal_done,              // Calibration sequence finished, pulse.
   input wire logic i_overrange,             // Primary input grossly overrange, level.
   input wire logic i_compare_thresh,        // Comparator threshold exceeded, level.
   input wire logic i_accum_thresh,          // Accumulator threshold exceeded, level.
   output logic o_primary_hold,              // Primary result write refused now.
   output logic o_aux_hold,                  // Auxiliary result write refused now.
   output logic [7:0] o_mode,                // Mode register value.
   output logic o_overrange_en,              // Overrange detection enabled.
   output logic [3:0] o_primary_gain,        // Primary gain setting.
   output logic o_irq                        // Converter interrupt request, level.
);
   localparam int CW = (OVR_TICK_CYCLES > 1) ? $clog2(OVR_TICK_CYCLES) : 1;
   localparam logic [CW-1:0] TICK_LAST = CW'(OVR_TICK_CYCLES - 1);

   // Refuse divider lengths and result widths the logic cannot serve.
   if (OVR_TICK_CYCLES < 2) begin : g_bad_tick
      $error("OVR_TICK_CYCLES must be at least 2");
   end
   if (RES_W < 1 || RES_W > 32) begin : g_bad_width
      $error("RES_W must be between 1 and 32");
   end

   asi_csr_if csr ();

   asi_axil_slave u_slave (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .csr(csr)
   );

   logic [CW-1:0] tick_cnt_q;
   logic ovr_tick;
   logic [7:0] mask_q;
   logic [7:0] mode_q;
   logic [7:0] cfg_q;
   logic [7:0] pctrl_q;
   logic [RES_W-1:0] pdata_q;
   logic [RES_W-1:0] adata_q;
   logic prdy_q;
   logic ardy_q;
   logic aux_read_seen_q;
   logic ovr_q;
   logic irq_q;
   logic [15:0] status;
   logic lane0_wr;
   logic wr_mask;
   logic wr_mode;
   logic wr_clear;
   logic wr_cfg;
   logic wr_pctrl;
   logic rd_pdata;
   logic rd_adata;
   logic continuous;
   logic primary_take;
   logic aux_take;
   logic gain_change;
   logic ovr_disable;

   // Write and read decode of the register window.
   assign lane0_wr = csr.wr_en && csr.wr_strb[0];
   assign wr_mask = lane0_wr && asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_MASK);
   assign wr_mode = lane0_wr && asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_MODE);
   assign wr_clear = lane0_wr && asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_CLEAR);
   assign wr_cfg = lane0_wr && asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_CONFIG);
   assign wr_pctrl = lane0_wr && asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_PCTRL);
   assign rd_pdata = csr.rd_en && asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_PDATA);
   assign rd_adata = csr.rd_en && asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_ADATA);

   // Overrange flag clear causes: detection switched off, or gain rewritten to a new value.
   assign gain_change = wr_pctrl &&
      (csr.wr_data[asi_pkg::GAIN_LSB +: asi_pkg::GAIN_W] != pctrl_q[asi_pkg::GAIN_LSB +: asi_pkg::GAIN_W]);
   assign ovr_disable = wr_cfg && !csr.wr_data[asi_pkg::CFG_OVR_EN_BIT];

   // A pending unread result blocks the next one in continuous mode.
   assign continuous = mode_q[asi_pkg::MODE_LSB +: asi_pkg::MODE_W] == asi_pkg::MODE_CONTINUOUS;
   assign o_primary_hold = continuous && prdy_q;
   assign o_aux_hold = continuous && ardy_q;
   assign primary_take = i_primary_wr && !o_primary_hold;
   assign aux_take = i_aux_wr && !o_aux_hold;

   // The 125 us re-evaluation tick from a free-running divider.
   assign ovr_tick = tick_cnt_q == TICK_LAST;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tick_cnt_q <= '0;
      end else if (ovr_tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + CW'(1);
      end
   end

   // Interrupt mask register with reserved bits held at zero.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         mask_q <= asi_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask_q <= csr.wr_data[7:0] & asi_pkg::MASK_WRITABLE;
      end
   end

   // Mode register, eight bits, fully writable.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         mode_q <= asi_pkg::MODE_RST;
      end else if (wr_mode) begin
         mode_q <= csr.wr_data[7:0];
      end
   end

   // Configuration and primary control registers.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cfg_q <= asi_pkg::CFG_RST;
         pctrl_q <= asi_pkg::PCTRL_RST;
      end else begin
         if (wr_cfg) begin
            cfg_q <= csr.wr_data[7:0];
         end
         if (wr_pctrl) begin
            pctrl_q <= csr.wr_data[7:0];
         end
      end
   end

   // Result data registers load only on an accepted write.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pdata_q <= '0;
         adata_q <= '0;
      end else begin
         if (primary_take) begin
            pdata_q <= i_primary_res;
         end
         if (aux_take) begin
            adata_q <= i_aux_res;
         end
      end
   end

   // Primary ready: set by an enabled result or calibration end, cleared by reading it; set wins.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         prdy_q <= 1'b0;
      end else if ((primary_take && i_primary_en) || i_cal_done) begin
         prdy_q <= 1'b1;
      end else if (rd_pdata || (wr_clear && csr.wr_data[asi_pkg::BIT_PRDY])) begin
         prdy_q <= 1'b0;
      end
   end

   // Remembers that the auxiliary result was read since the last primary read.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         aux_read_seen_q <= 1'b0;
      end else if (rd_adata) begin
         aux_read_seen_q <= 1'b1;
      end else if (rd_pdata) begin
         aux_read_seen_q <= 1'b0;
      end
   end

   // Auxiliary ready: cleared by the aux-then-primary read pair or a clear write of its bit; set wins.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ardy_q <= 1'b0;
      end else if ((aux_take && i_aux_en) || i_cal_done) begin
         ardy_q <= 1'b1;
      end else if ((rd_pdata && aux_read_seen_q) || (wr_clear && csr.wr_data[asi_pkg::BIT_ARDY])) begin
         ardy_q <= 1'b0;
      end
   end

   // Overrange flag: sampled on the tick while enabled, sticky until disable or gain change.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ovr_q <= 1'b0;
      end else if (ovr_tick && cfg_q[asi_pkg::CFG_OVR_EN_BIT] && i_overrange) begin
         ovr_q <= 1'b1;
      end else if (ovr_disable || gain_change) begin
         ovr_q <= 1'b0;
      end
   end

   // Status word; threshold bits follow their live conditions, reserved bits read zero.
   always_comb begin
      status = 16'h0;
      status[asi_pkg::BIT_PRDY] = prdy_q;
      status[asi_pkg::BIT_ARDY] = ardy_q;
      status[asi_pkg::BIT_OVR] = ovr_q;
      status[asi_pkg::BIT_CTH] = i_compare_thresh;
      status[asi_pkg::BIT_ATH] = i_accum_thresh;
   end

   // Interrupt request from the masked low status byte.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status[7:0] & mask_q);
      end
   end

   // Read multiplexer; unmapped addresses answer zero with an error.
   always_comb begin
      csr.rd_data = 32'h0;
      csr.rd_ok = 1'b1;
      if (asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_STATUS)) begin
         csr.rd_data[15:0] = status;
      end else if (asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_MASK)) begin
         csr.rd_data[7:0] = mask_q;
      end else if (asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_MODE)) begin
         csr.rd_data[7:0] = mode_q;
      end else if (asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_CLEAR)) begin
         csr.rd_data = 32'h0;
      end else if (asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_CONFIG)) begin
         csr.rd_data[7:0] = cfg_q;
      end else if (asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_PCTRL)) begin
         csr.rd_data[7:0] = pctrl_q;
      end else if (asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_PDATA)) begin
         csr.rd_data[RES_W-1:0] = pdata_q;
      end else if (asi_pkg::addr_hit(csr.rd_addr, asi_pkg::ADDR_ADATA)) begin
         csr.rd_data[RES_W-1:0] = adata_q;
      end else begin
         csr.rd_ok = 1'b0;
      end
   end

   // Write acceptance; the status register is read-only and writes to it are ignored.
   always_comb begin
      csr.wr_ok = asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_STATUS) ||
                  asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_MASK) ||
                  asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_MODE) ||
                  asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_CLEAR) ||
                  asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_CONFIG) ||
                  asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_PCTRL) ||
                  asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_PDATA) ||
                  asi_pkg::addr_hit(csr.wr_addr, asi_pkg::ADDR_ADATA);
   end

   // Register values toward the converter core.
   assign o_mode = mode_q;
   assign o_overrange_en = cfg_q[asi_pkg::CFG_OVR_EN_BIT];
   assign o_primary_gain = pctrl_q[asi_pkg::GAIN_LSB +: asi_pkg::GAIN_W];
   assign o_irq = irq_q;
endmodule
`default_nettype wire

// ===== testbench/asi_top_sva.sv
`default_nettype none
module asi_top_sva (
   input wire logic i_clk,            // System clock.
   input wire logic i_sys_rst,        // Synchronous reset.
   input wire logic i_primary_en,     // Primary converter enabled.
   input wire logic i_aux_en,         // Auxiliary converter enabled.
   input wire logic i_primary_wr,     // Primary result strobe.
   input wire logic i_aux_wr,         // Auxiliary result strobe.
   input wire logic i_cal_done,       // Calibration end pulse.
   input wire logic i_bready,         // Write response ready.
   input wire logic i_rready,         // Read data ready.
   input wire logic o_bvalid,         // Write response valid.
   input wire logic o_rvalid,         // Read data valid.
   input wire logic [31:0] o_rdata,   // Read data.
   input wire logic [7:0] o_mode,     // Mode register value.
   input wire logic o_primary_hold,   // Primary strobe refused.
   input wire logic o_aux_hold,       // Auxiliary strobe refused.
   input wire logic o_irq             // Interrupt request.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cont;

   // Continuous conversion is the only mode in which results are held back.
   assign cont = o_mode[2:0] == 3'h1;

   // All checks share the system clock and its reset.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   a_mode_reset: assert property ($fell(i_sys_rst) |-> o_mode == 8'h03)
      else $error("mode register not at reset value");
   a_irq_quiet_reset: assert property ($fell(i_sys_rst) |-> !o_irq ##1 !o_irq)
      else $error("interrupt raised right after reset");
   a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped before taken");
   a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data changed before taken");
   a_hold_only_cont: assert property (o_primary_hold || o_aux_hold |-> cont)
      else $error("result held outside continuous mode");
   a_prdy_sets: assert property (cont && i_primary_en && i_primary_wr && !o_primary_hold |=> o_primary_hold || !cont)
      else $error("primary result did not set ready");
   a_ardy_sets: assert property (cont && i_aux_en && i_aux_wr && !o_aux_hold |=> o_aux_hold || !cont)
      else $error("auxiliary result did not set ready");
   a_cal_sets: assert property (cont && i_cal_done |=> (o_primary_hold && o_aux_hold) || !cont)
      else $error("calibration end did not set both ready flags");

   // Main scenarios reached.
   c_irq: cover property (o_irq);
   c_drop: cover property (o_primary_hold && i_primary_wr);
   c_write: cover property (o_bvalid && i_bready);
endmodule

bind asi_top asi_top_sva u_sva (.i_clk, .i_sys_rst, .i_primary_en, .i_aux_en, .i_primary_wr, .i_aux_wr,
   .i_cal_done, .i_bready, .i_rready, .o_bvalid, .o_rvalid, .o_rdata, .o_mode, .o_primary_hold, .o_aux_hold, .o_irq);
`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OVR = 8;
   localparam logic [1:0] OK = asi_pkg::RESP_OKAY;
   logic i_clk = 0, i_sys_rst = 1;
   logic [31:0] i_awaddr = 0, i_wdata = 0, i_araddr = 0, i_primary_res = 0, i_aux_res = 0, o_rdata;
   logic [3:0] i_wstrb = 4'hf, o_primary_gain;
   logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
   logic i_primary_en = 1, i_aux_en = 1, i_primary_wr = 0, i_aux_wr = 0, i_cal_done = 0;
   logic i_overrange = 0, i_compare_thresh = 0, i_accum_thresh = 0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_primary_hold, o_aux_hold, o_overrange_en, o_irq;
   logic [1:0] o_bresp, o_rresp;
   logic [7:0] o_mode;
   int fail_count = 0, check_count = 0;

   asi_top #(.OVR_TICK_CYCLES(OVR), .RES_W(32)) dut (.i_clk, .i_sys_rst, .i_awaddr, .i_awvalid, .o_awready,
      .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_primary_en, .i_aux_en, .i_primary_wr,
      .i_primary_res, .i_aux_wr, .i_aux_res, .i_cal_done, .i_overrange, .i_compare_thresh, .i_accum_thresh,
      .o_primary_hold, .o_aux_hold, .o_mode, .o_overrange_en, .o_primary_gain, .o_irq);

   // A 50 MHz system clock.
   always #10 i_clk = ~i_clk;

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // One AXI write; address and data are offered together and released as each is taken.
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = OK);
      logic aw;
      logic w;
      aw = 0;
      w = 0;
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge i_clk);
         if (i_awvalid && o_awready) begin
            aw = 1;
            i_awvalid <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w = 1;
            i_wvalid <= 1'b0;
         end
      end
      i_bready <= 1'b1;
      do @(posedge i_clk); while (!o_bvalid);
      i_bready <= 1'b0;
      chk({30'h0, o_bresp}, {30'h0, er});
   endtask

   // One AXI read, compared with the expected word and response.
   task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er = OK);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      do @(posedge i_clk); while (!o_arready);
      i_arvalid <= 1'b0;
      i_rready <= 1'b1;
      do @(posedge i_clk); while (!o_rvalid);
      i_rready <= 1'b0;
      chk(o_rdata, e);
      chk({30'h0, o_rresp}, {30'h0, er});
   endtask

   // One-cycle core strobes, then a cycle for the flags to land.
   task automatic core(input logic p, input logic x, input logic c, input logic [31:0] d);
      i_primary_wr <= p;
      i_aux_wr <= x;
      i_cal_done <= c;
      i_primary_res <= d;
      i_aux_res <= d;
      @(posedge i_clk);
      i_primary_wr <= 1'b0;
      i_aux_wr <= 1'b0;
      i_cal_done <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Cuts a hang short well past the expected run length.
   initial begin
      tick(20000);
      fail_count++;
      conclude();
   end

   // Main sequence.
   initial begin
      tick(4);
      i_sys_rst <= 1'b0;
      tick(1);
      rdc(asi_pkg::ADDR_MASK, 32'h0);
      rdc(asi_pkg::ADDR_MODE, 32'h3);
      rdc(asi_pkg::ADDR_STATUS, 32'h0);
      rdc(32'hffff0600, 32'h0, asi_pkg::RESP_SLVERR);
      wr(32'hffff0600, 32'h1, asi_pkg::RESP_SLVERR);
      wr(asi_pkg::ADDR_MASK, 32'hff);
      rdc(asi_pkg::ADDR_MASK, 32'h5b);
      wr(asi_pkg::ADDR_MASK, 32'h0);
      // A primary result raises its flag and, once enabled, the interrupt.
      core(1, 0, 0, 32'h12345678);
      rdc(asi_pkg::ADDR_STATUS, 32'h1);
      chk({31'h0, o_irq}, 32'h0);
      wr(asi_pkg::ADDR_MASK, 32'h1);
      tick(2);
      chk({31'h0, o_irq}, 32'h1);
      rdc(asi_pkg::ADDR_PDATA, 32'h12345678);
      tick(2);
      chk({31'h0, o_irq}, 32'h0);
      // The auxiliary flag needs an auxiliary read followed by a primary read.
      core(0, 1, 0, 32'h0000beef);
      rdc(asi_pkg::ADDR_PDATA, 32'h12345678);
      rdc(asi_pkg::ADDR_STATUS, 32'h2);
      rdc(asi_pkg::ADDR_ADATA, 32'h0000beef);
      rdc(asi_pkg::ADDR_STATUS, 32'h2);
      rdc(asi_pkg::ADDR_PDATA, 32'h12345678);
      rdc(asi_pkg::ADDR_STATUS, 32'h0);
      // Disabled converters do not flag results; calibration end flags both.
      i_primary_en <= 1'b0;
      i_aux_en <= 1'b0;
      core(1, 1, 0, 32'h5);
      rdc(asi_pkg::ADDR_STATUS, 32'h0);
      i_primary_en <= 1'b1;
      i_aux_en <= 1'b1;
      core(0, 0, 1, 32'h0);
      rdc(asi_pkg::ADDR_STATUS, 32'h3);
      wr(asi_pkg::ADDR_CLEAR, 32'h3);
      rdc(asi_pkg::ADDR_STATUS, 32'h0);
      // Overrange is sampled on the tick and sticks until disable or gain change.
      wr(asi_pkg::ADDR_MASK, 32'h8);
      wr(asi_pkg::ADDR_CONFIG, 32'h4);
      chk({31'h0, o_overrange_en}, 32'h1);
      i_overrange <= 1'b1;
      tick(OVR + 2);
      i_overrange <= 1'b0;
      rdc(asi_pkg::ADDR_STATUS, 32'h8);
      chk({31'h0, o_irq}, 32'h1);
      tick(OVR + 2);
      wr(asi_pkg::ADDR_CLEAR, 32'h3);
      rdc(asi_pkg::ADDR_STATUS, 32'h8);
      wr(asi_pkg::ADDR_PCTRL, 32'h1);
      chk({28'h0, o_primary_gain}, 32'h1);
      rdc(asi_pkg::ADDR_STATUS, 32'h0);
      i_overrange <= 1'b1;
      tick(OVR + 2);
      i_overrange <= 1'b0;
      rdc(asi_pkg::ADDR_STATUS, 32'h8);
      wr(asi_pkg::ADDR_CONFIG, 32'h0);
      rdc(asi_pkg::ADDR_STATUS, 32'h0);
      // Threshold bits follow their inputs; only unmasked ones interrupt.
      wr(asi_pkg::ADDR_MASK, 32'h10);
      i_accum_thresh <= 1'b1;
      tick(2);
      rdc(asi_pkg::ADDR_STATUS, 32'h40);
      chk({31'h0, o_irq}, 32'h0);
      i_accum_thresh <= 1'b0;
      i_compare_thresh <= 1'b1;
      tick(2);
      rdc(asi_pkg::ADDR_STATUS, 32'h10);
      chk({31'h0, o_irq}, 32'h1);
      i_compare_thresh <= 1'b0;
      tick(2);
      chk({31'h0, o_irq}, 32'h0);
      // Continuous mode drops new results until the flag is cleared.
      wr(asi_pkg::ADDR_MODE, 32'h1);
      chk({24'h0, o_mode}, 32'h1);
      rdc(asi_pkg::ADDR_MODE, 32'h1);
      core(1, 1, 0, 32'h000000a1);
      chk({31'h0, o_primary_hold}, 32'h1);
      chk({31'h0, o_aux_hold}, 32'h1);
      core(1, 1, 0, 32'h000000b2);
      rdc(asi_pkg::ADDR_ADATA, 32'h000000a1);
      rdc(asi_pkg::ADDR_PDATA, 32'h000000a1);
      chk({31'h0, o_primary_hold}, 32'h0);
      chk({31'h0, o_aux_hold}, 32'h0);
      // Calibration end in continuous mode, then a reset in mid-run.
      wr(asi_pkg::ADDR_MASK, 32'h3);
      core(0, 0, 1, 32'h0);
      chk({31'h0, o_primary_hold & o_aux_hold}, 32'h1);
      tick(1);
      chk({31'h0, o_irq}, 32'h1);
      i_sys_rst <= 1'b1;
      tick(2);
      i_sys_rst <= 1'b0;
      tick(1);
      chk({31'h0, o_irq}, 32'h0);
      rdc(asi_pkg::ADDR_MODE, 32'h3);
      rdc(asi_pkg::ADDR_MASK, 32'h0);
      rdc(asi_pkg::ADDR_STATUS, 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
